/* test/adp_chain_assertions.sv */
// checker for the dynamics chain: sample strobe, read port and checksums
`timescale 1ns/1ps
module adp_chain_assertions (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic smp_en,
  input wire adp_pkg::adp_stereo_t smp_in,
  input wire adp_pkg::adp_stereo_t smp_out,
  input wire logic smp_valid,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  logic [7:0] bk;
  logic [7:0] pg;
  logic [7:0] crc_m;
  logic [7:0] xor_m;
  logic sel_wr;
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ adp_pkg::CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc_step
  // book and page selects never reach either checksum
  assign sel_wr = reg_wr && reg_addr != 8'h00 && reg_addr != 8'h7f;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bk <= 8'h00;
      pg <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h7f) begin
      bk <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h00) begin
      pg <= reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      crc_m <= 8'h00;
    end else if (sel_wr && reg_addr == 8'h7e && (bk == 8'h00 || pg == 8'h00)) begin
      crc_m <= reg_wdata;
    end else if (sel_wr) begin
      crc_m <= crc_step(crc_m, reg_wdata);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xor_m <= 8'h00;
    end else if (sel_wr && reg_addr == 8'h7d && bk == 8'h8c && pg == 8'h00) begin
      xor_m <= reg_wdata;
    end else if (sel_wr && bk == 8'h8c && pg != 8'h00) begin
      xor_m <= xor_m ^ reg_wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  valid_after_strobe_a: assert property (smp_en |=> smp_valid)
    else $error("sample valid missing after strobe");
  valid_has_cause_a: assert property (smp_valid |-> $past(smp_en))
    else $error("sample valid without strobe");
  out_moves_valid_a: assert property ($changed(smp_out) |-> $past(smp_valid))
    else $error("sample output moved without valid");
  reset_clears_a: assert property (disable iff (1'b0) srst |=>
    smp_out == '0 && reg_rdata == 8'h00 && !smp_valid)
    else $error("outputs not cleared by reset");
  rdata_holds_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  crc_read_a: assert property (reg_rd && reg_addr == 8'h7e && (bk == 8'h00 || pg == 8'h00)
    |=> reg_rdata == $past(crc_m))
    else $error("crc checksum read wrong");
  xor_read_a: assert property (reg_rd && reg_addr == 8'h7d && bk == 8'h8c && pg == 8'h00
    |=> reg_rdata == $past(xor_m))
    else $error("xor checksum read wrong");
  crc_hidden_a: assert property (reg_rd && reg_addr == 8'h7e && bk == 8'h8c && pg == 8'h20
    |=> reg_rdata == 8'h00)
    else $error("crc visible off page zero");
  cover property (smp_en ##1 smp_valid);
  cover property (reg_rd && reg_addr == 8'h7e && bk == 8'h8c && pg == 8'h00);
  cover property (reg_rd && reg_addr == 8'h7d && bk == 8'h8c && pg == 8'h00);
endmodule : adp_chain_assertions

/* test/adp_source_model.sv */
// sample source standing in for the preceding conversion and filter stages
`timescale 1ns/1ps
module adp_source_model #(
  parameter int PERIOD = 8
) (
  input wire logic clk_sys,
  input wire logic run,
  output logic smp_en,
  output adp_pkg::adp_stereo_t smp_in
);
  int cnt;
  logic [31:0] seq;
  initial begin
    smp_en = 1'b0;
    smp_in = '0;
    cnt = 0;
    seq = 32'h00000000;
  end
  // off the strobe the samples toggle so a late capture cannot pass unseen
  always @(negedge clk_sys) begin
    if (!run) begin
      smp_en <= 1'b0;
      cnt <= 0;
      smp_in <= ~smp_in;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      smp_en <= (cnt == 0);
      smp_in <= (cnt == 0) ? {seq, 32'h00000000 - seq} : ~smp_in;
      if (cnt == 0) begin
        seq <= seq + 32'h01000000;
      end
    end
  end
endmodule : adp_source_model

/* test/tb.sv */
// self-checking bench for the dynamics chain register port and sample flow
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] ofs;
    logic [31:0] word;
  } adp_row_t;
  logic clk_sys;
  logic srst;
  logic run;
  logic smp_en;
  logic smp_valid;
  adp_pkg::adp_stereo_t smp_in;
  adp_pkg::adp_stereo_t smp_out;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] bk_e;
  logic [7:0] pg_e;
  logic [7:0] crc_e;
  logic [7:0] xor_e;
  logic [31:0] got;
  int fails;
  int cmp_count;
  int n;
  adp_row_t rows [3];
  adp_chain adp_chain_i (.clk_sys(clk_sys), .srst(srst), .smp_en(smp_en), .smp_in(smp_in),
    .smp_out(smp_out), .smp_valid(smp_valid), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  adp_source_model adp_source_model_i (.clk_sys(clk_sys), .run(run), .smp_en(smp_en),
    .smp_in(smp_in));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction : crc_next
  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task do_reset;
    srst = 1'b1;
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    bk_e = 8'h00;
    pg_e = 8'h00;
    crc_e = 8'h00;
    xor_e = 8'h00;
  endtask : do_reset
  // expected checksums follow every byte write alongside the device
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    if (a == 8'h7f) bk_e = d;
    else if (a == 8'h00) pg_e = d;
    else begin
      crc_e = crc_next(crc_e, d);
      if (bk_e == 8'h8c && pg_e != 8'h00) xor_e = xor_e ^ d;
      if (a == 8'h7e && (bk_e == 8'h00 || pg_e == 8'h00)) crc_e = d;
      if (a == 8'h7d && bk_e == 8'h8c && pg_e == 8'h00) xor_e = d;
    end
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask : rd
  task wr_word(input logic [7:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) wr(a + 8'(i), w[31 - 8 * i -: 8]);
  endtask : wr_word
  task rd_word(input logic [7:0] a, output logic [31:0] w);
    for (int i = 0; i < 4; i++) rd(a + 8'(i), w[31 - 8 * i -: 8]);
  endtask : rd_word
  initial begin
    {srst, run, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    fails = 0;
    cmp_count = 0;
    // smallest step, top and bottom of the signed 1.31 range in the blend words
    rows = '{'{8'h58, 32'h00000001}, '{8'h5c, 32'h7fffffff}, '{8'h60, 32'h80000000}};
    do_reset();
    check("reset data", reg_rdata, 8'h00);
    check("reset out", smp_out, 64'h0);
    wr(8'h30, 8'ha5);
    wr(8'h31, 8'h3c);
    rd(8'h7e, got[7:0]);
    check("crc book0", got[7:0], crc_e);
    rd(8'h7e, got[7:0]);
    check("crc after read", got[7:0], crc_e);
    wr(8'h00, 8'h05);
    rd(8'h7e, got[7:0]);
    check("crc other page", got[7:0], crc_e);
    wr(8'h00, 8'h00);
    wr(8'h7f, 8'h8c);
    wr(8'h00, 8'h20);
    foreach (rows[i]) begin
      wr_word(rows[i].ofs, rows[i].word);
      rd_word(rows[i].ofs, got);
      check("blend word", got, rows[i].word);
    end
    rd(8'h7e, got[7:0]);
    check("crc off page", got[7:0], 8'h00);
    wr(8'h00, 8'h21);
    wr_word(8'h70, 32'h00000001); // meter takes processed audio
    rd_word(8'h70, got);
    check("meter select", got, 32'h00000001);
    wr(8'h00, 8'h23);
    wr_word(8'h10, 32'h00000200);
    wr_word(8'h14, 32'h00000100);
    wr_word(8'h18, 32'h00100000);
    wr(8'h00, 8'h24);
    // unity b0 on the low-level and crossover low-pass sections
    wr_word(8'h1c, 32'h7fffffff);
    wr_word(8'h44, 32'h7fffffff);
    wr(8'h00, 8'h00);
    rd(8'h7d, got[7:0]);
    check("xor sum", got[7:0], xor_e);
    rd(8'h7e, got[7:0]);
    check("crc page0", got[7:0], crc_e);
    wr(8'h7d, 8'h00);
    wr(8'h7e, 8'h00);
    rd(8'h7d, got[7:0]);
    check("xor cleared", got[7:0], xor_e);
    rd(8'h7e, got[7:0]);
    check("crc cleared", got[7:0], 8'h00);
    run = 1'b1;
    n = 0;
    for (int c = 0; c < 400 && n < 12; c++) begin
      @(negedge clk_sys);
      if (smp_valid === 1'b1) n++;
    end
    check("valid count", n, 12);
    if (n < 12) conclude();
    // ramp far above the clip level on both channels
    check("clip out", smp_out, {32'h00100000, 32'hfff00000});
    // reset while samples still flow
    do_reset();
    run = 1'b0;
    check("mid reset out", smp_out, 64'h0);
    rd(8'h7e, got[7:0]);
    check("crc after reset", got[7:0], 8'h00);
    conclude();
  end
endmodule : tb
bind adp_chain adp_chain_assertions adp_chain_assertions_i (.clk_sys(clk_sys), .srst(srst),
  .smp_en(smp_en), .smp_in(smp_in), .smp_out(smp_out), .smp_valid(smp_valid),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata));

/* verilog/adp_biquad.sv */
// direct form 1 biquad section with 1.31 coefficients
`timescale 1ns/1ps
module adp_biquad (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic smp_en,
  input wire adp_pkg::adp_bq_t coef,
  input wire logic signed [adp_pkg::DW-1:0] din,
  output logic signed [adp_pkg::DW-1:0] dout
);
  logic signed [31:0] x1, x2, y1, y2;
  logic signed [65:0] acc;
  logic signed [31:0] next_y;
  // b1 and a1 are stored halved, so their products count twice
  always_comb begin
    acc = 66'(signed'(coef.b0) * din) + 66'(signed'(coef.b1) * x1) * 2
        + 66'(signed'(coef.b2) * x2) + 66'(signed'(coef.a1) * y1) * 2
        + 66'(signed'(coef.a2) * y2);
    if (acc[65:62] != {4{acc[65]}})
      next_y = acc[65] ? 32'sh80000000 : 32'sh7fffffff;
    else
      next_y = acc[62:31];
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
    end else if (smp_en) begin
      x1 <= din;
      x2 <= x1;
      y1 <= next_y;
      y2 <= y1;
    end
  end
  assign dout = y1;
endmodule : adp_biquad

/* verilog/adp_chain.sv */
// stereo dynamics chain: equaliser, compressors, limiter, volume, meter, checksums
`timescale 1ns/1ps
module adp_chain (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic smp_en,
  input wire adp_pkg::adp_stereo_t smp_in,
  output adp_pkg::adp_stereo_t smp_out,
  output logic smp_valid,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata
);
  localparam int DW = adp_pkg::DW;
  // limiter word slots
  localparam int LW_SOFTEN = 0;
  localparam int LW_THRESH = 1;
  localparam int LW_ATTACK = 2;
  localparam int LW_RELEASE = 3;
  localparam int LW_CLIP = 4;
  // byte-wide control port, big-endian words at 4-byte slots
  logic [7:0] book, page;
  logic [7:0] crc, xsum;
  logic [DW-1:0] shreg;
  logic [DW-1:0] eq_alpha, eq_gain, eq_offset, sense_gain, fine_vol, boost, meter_alpha;
  logic meter_sel;
  logic [DW-1:0] cmp_w [2][adp_pkg::CMP_WORDS];
  logic [DW-1:0] lim_w [adp_pkg::LIM_WORDS];
  logic [DW-1:0] bq_w [adp_pkg::BQ_COUNT*5];
  logic [DW-1:0] meter_l, meter_r;
  logic word_done;
  logic [7:0] waddr;
  logic [7:0] next_crc;
  assign word_done = reg_wr && (reg_addr[1:0] == 2'b11);
  assign waddr = {reg_addr[7:2], 2'b00};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      book <= adp_pkg::BOOK_ZERO;
      page <= adp_pkg::PAGE_ZERO;
      shreg <= '0;
    end else if (reg_wr) begin
      if (reg_addr == adp_pkg::REG_PAGE_SEL) page <= reg_wdata;
      else if (reg_addr == adp_pkg::REG_BOOK_SEL) book <= reg_wdata;
      shreg <= {shreg[23:0], reg_wdata};
    end
  end
  always_comb begin
    next_crc = crc ^ reg_wdata;
    for (int i = 0; i < 8; i++)
      next_crc = next_crc[7] ? ((next_crc << 1) ^ adp_pkg::CRC_POLY) : (next_crc << 1);
  end
  logic chk_wr, crc_loc, xor_loc, xor_cov;
  assign chk_wr = reg_wr && reg_addr != adp_pkg::REG_PAGE_SEL
               && reg_addr != adp_pkg::REG_BOOK_SEL;
  // only a checksum's own byte reloads it; both share one word slot
  assign crc_loc = reg_addr == adp_pkg::REG_CRC &&
                   (book == adp_pkg::BOOK_ZERO || page == adp_pkg::PAGE_ZERO);
  assign xor_loc = reg_addr == adp_pkg::REG_XOR &&
                   book == adp_pkg::BOOK_COEF && page == adp_pkg::PAGE_ZERO;
  assign xor_cov = book == adp_pkg::BOOK_COEF && page != adp_pkg::PAGE_ZERO;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      crc <= adp_pkg::CHK_RESET;
      xsum <= adp_pkg::CHK_RESET;
    end else if (chk_wr) begin
      if (crc_loc) crc <= reg_wdata;
      else crc <= next_crc;
      if (xor_loc) xsum <= reg_wdata;
      else if (xor_cov) xsum <= xsum ^ reg_wdata;
    end
  end
  logic [DW-1:0] wword;
  assign wword = {shreg[23:0], reg_wdata};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      eq_alpha <= adp_pkg::ALPHA_DEF;
      eq_gain <= '0;
      eq_offset <= '0;
      sense_gain <= adp_pkg::UNITY_Q824;
      fine_vol <= adp_pkg::UNITY_Q230;
      boost <= adp_pkg::UNITY_Q230;
      meter_alpha <= adp_pkg::ALPHA_DEF;
      meter_sel <= 1'b0;
    end else if (word_done && book == adp_pkg::BOOK_COEF) begin
      if (page == adp_pkg::PAGE_EQ) begin
        if (waddr == adp_pkg::OFS_EQ_ALPHA) eq_alpha <= wword;
        if (waddr == adp_pkg::OFS_EQ_GAIN) eq_gain <= wword;
        if (waddr == adp_pkg::OFS_EQ_OFFSET) eq_offset <= wword;
        if (waddr == adp_pkg::OFS_SENSE_GAIN) sense_gain <= wword;
      end
      if (page == adp_pkg::PAGE_MISC) begin
        if (waddr == adp_pkg::OFS_METER_SEL) meter_sel <= wword[0];
        if (waddr == adp_pkg::OFS_FINE_VOL) fine_vol <= wword;
        if (waddr == adp_pkg::OFS_BOOST) boost <= wword;
        if (waddr == adp_pkg::OFS_METER_ALPHA) meter_alpha <= wword;
      end
    end
  end
  // compressor, limiter and biquad coefficient arrays
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int b = 0; b < 2; b++)
        for (int w = 0; w < adp_pkg::CMP_WORDS; w++) cmp_w[b][w] <= '0;
      for (int w = 0; w < adp_pkg::LIM_WORDS; w++) lim_w[w] <= '0;
      for (int w = 0; w < adp_pkg::BQ_COUNT*5; w++) bq_w[w] <= '0;
    end else if (word_done && book == adp_pkg::BOOK_COEF) begin
      for (int b = 0; b < 2; b++)
        for (int w = 0; w < adp_pkg::CMP_WORDS; w++)
          if (page == adp_pkg::PAGE_CMP && waddr == 8'(adp_pkg::OFS_CMP_BASE
              + b*adp_pkg::OFS_CMP_STRIDE + 4*w)) cmp_w[b][w] <= wword;
      for (int w = 0; w < adp_pkg::LIM_WORDS; w++)
        if (page == adp_pkg::PAGE_LIM && waddr == 8'(adp_pkg::OFS_LIM_BASE + 4*w))
          lim_w[w] <= wword;
      for (int w = 0; w < adp_pkg::BQ_COUNT*5; w++)
        if (page == adp_pkg::PAGE_BQ && waddr == 8'(adp_pkg::OFS_BQ_BASE + 4*w))
          bq_w[w] <= wword;
    end
  end
  // read mux: byte of a word, big-endian
  logic [DW-1:0] rword;
  always_comb begin
    rword = '0;
    if (book == adp_pkg::BOOK_COEF && page == adp_pkg::PAGE_EQ) begin
      if (waddr == adp_pkg::OFS_EQ_ALPHA) rword = eq_alpha;
      if (waddr == adp_pkg::OFS_EQ_GAIN) rword = eq_gain;
      if (waddr == adp_pkg::OFS_EQ_OFFSET) rword = eq_offset;
    end
    if (book == adp_pkg::BOOK_COEF && page == adp_pkg::PAGE_MISC) begin
      if (waddr == adp_pkg::OFS_METER_L) rword = meter_l;
      if (waddr == adp_pkg::OFS_METER_R) rword = meter_r;
      if (waddr == adp_pkg::OFS_METER_SEL) rword = {31'h0, meter_sel};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) reg_rdata <= '0;
    else if (reg_rd) begin
      if (reg_addr == adp_pkg::REG_PAGE_SEL) reg_rdata <= page;
      else if (reg_addr == adp_pkg::REG_BOOK_SEL) reg_rdata <= book;
      else if (reg_addr == adp_pkg::REG_CRC && (book == adp_pkg::BOOK_ZERO
               || page == adp_pkg::PAGE_ZERO)) reg_rdata <= crc;
      else if (reg_addr == adp_pkg::REG_XOR && book == adp_pkg::BOOK_COEF
               && page == adp_pkg::PAGE_ZERO) reg_rdata <= xsum;
      else reg_rdata <= rword[8*(3-reg_addr[1:0]) +: 8];
    end
  end
  // fixed point helpers
  function automatic logic signed [31:0] mulq(input logic signed [31:0] a,
      input logic signed [31:0] b, input int fr);
    logic signed [63:0] p;
    logic signed [63:0] s;
    p = a * b;
    s = p >>> fr;
    if (s > 64'sh7fffffff) mulq = 32'sh7fffffff;
    else if (s < -64'sh80000000) mulq = 32'sh80000000;
    else mulq = s[31:0];
  endfunction : mulq
  function automatic logic signed [31:0] sadd(input logic signed [31:0] a,
      input logic signed [31:0] b);
    logic signed [32:0] s;
    s = 33'(a) + 33'(b);
    sadd = (s[32] != s[31]) ? (s[32] ? 32'sh80000000 : 32'sh7fffffff) : s[31:0];
  endfunction : sadd
  // alpha energy filter: e += alpha*(|x| - e)
  function automatic logic signed [31:0] energy(input logic signed [31:0] e,
      input logic signed [31:0] x, input logic signed [31:0] a);
    logic signed [31:0] m;
    m = x[31] ? ((x == 32'sh80000000) ? 32'sh7fffffff : -x) : x;
    energy = sadd(e, mulq(a, m - e, 31));
  endfunction : energy
  // clipped result per channel, left in slot 1
  logic signed [31:0] clip_y [2];
  logic signed [31:0] eq_out [2], cmp_out [2], lim_out [2];
  logic signed [31:0] eq_env [2], cmp_env [2][2], cmp_gain [2][2];
  logic signed [31:0] lim_env [2], lim_gain;
  adp_pkg::adp_lim_t lim_state;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic signed [31:0] x, hi_p, lo_p, sn_p, lp_p, hp_p, sense, blend;
      logic signed [31:0] mix, band_y [2], vol;
      assign x = ch ? smp_in.left : smp_in.right;
      // five dedicated biquads per channel share one coefficient bank
      adp_biquad u_hi (.clk_sys(clk_sys), .srst(srst), .smp_en(smp_en),
        .coef({bq_w[0], bq_w[1], bq_w[2], bq_w[3], bq_w[4]}), .din(x), .dout(hi_p));
      adp_biquad u_lo (.clk_sys(clk_sys), .srst(srst), .smp_en(smp_en),
        .coef({bq_w[5], bq_w[6], bq_w[7], bq_w[8], bq_w[9]}), .din(x), .dout(lo_p));
      adp_biquad u_sn (.clk_sys(clk_sys), .srst(srst), .smp_en(smp_en),
        .coef({bq_w[10], bq_w[11], bq_w[12], bq_w[13], bq_w[14]}), .din(x),
        .dout(sn_p));
      adp_biquad u_lp (.clk_sys(clk_sys), .srst(srst), .smp_en(smp_en),
        .coef({bq_w[15], bq_w[16], bq_w[17], bq_w[18], bq_w[19]}), .din(eq_out[ch]),
        .dout(lp_p));
      adp_biquad u_hp (.clk_sys(clk_sys), .srst(srst), .smp_en(smp_en),
        .coef({bq_w[20], bq_w[21], bq_w[22], bq_w[23], bq_w[24]}), .din(eq_out[ch]),
        .dout(hp_p));
      assign sense = mulq(sn_p, sense_gain, 24);
      // blend ratio = 32*gain*(env+offset), clamped to 0..1
      always_comb begin
        logic signed [31:0] d;
        d = sadd(eq_env[ch], eq_offset);
        blend = d[31] ? 32'sh0 : mulq(d, eq_gain, 26);
        if (blend[31]) blend = 32'sh7fffffff;
      end
      assign mix = sadd(mulq(hi_p, blend, 31), mulq(lo_p, 32'(adp_pkg::ONE_Q31 - blend), 31));
      for (genvar b = 0; b < 2; b++) begin : g_band
        logic signed [31:0] bx, target, lvl;
        assign bx = b ? hp_p : lp_p;
        // words: th_lo th_hi k_lo k_mid k_hi sh_lo sh_hi energy attack decay
        always_comb begin
          lvl = cmp_env[ch][b];
          if (lvl < signed'(cmp_w[b][0]))
            target = sadd(cmp_w[b][5], mulq(lvl - signed'(cmp_w[b][0]), cmp_w[b][2], 24));
          else if (lvl < signed'(cmp_w[b][1]))
            target = sadd(cmp_w[b][5], mulq(lvl - signed'(cmp_w[b][0]), cmp_w[b][3], 24));
          else
            target = sadd(cmp_w[b][6], mulq(lvl - signed'(cmp_w[b][1]), cmp_w[b][4], 24));
          target = sadd(32'(adp_pkg::UNITY_Q824), target);
        end
        assign band_y[b] = mulq(bx, cmp_gain[ch][b], 24);
        always_ff @(posedge clk_sys) begin
          if (srst) begin
            cmp_env[ch][b] <= '0;
            cmp_gain[ch][b] <= adp_pkg::UNITY_Q824;
          end else if (smp_en) begin
            cmp_env[ch][b] <= energy(cmp_env[ch][b], bx, cmp_w[b][7]);
            if (target < cmp_gain[ch][b])
              cmp_gain[ch][b] <= sadd(cmp_gain[ch][b], mulq(cmp_w[b][8], target - cmp_gain[ch][b], 31));
            else
              cmp_gain[ch][b] <= sadd(cmp_gain[ch][b], mulq(cmp_w[b][9], target - cmp_gain[ch][b], 31));
          end
        end
      end
      assign vol = mulq(mulq(lim_out[ch], fine_vol, 30), boost, 30);
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          eq_env[ch] <= '0;
          eq_out[ch] <= '0;
          cmp_out[ch] <= '0;
          lim_out[ch] <= '0;
          lim_env[ch] <= '0;
          clip_y[ch] <= '0;
        end else if (smp_en) begin
          eq_env[ch] <= energy(eq_env[ch], sense, eq_alpha);
          eq_out[ch] <= mix;
          cmp_out[ch] <= sadd(band_y[0], band_y[1]);
          lim_out[ch] <= mulq(cmp_out[ch], lim_gain, 24);
          lim_env[ch] <= energy(lim_env[ch], lim_out[ch], lim_w[LW_SOFTEN]);
          // clip below rail at the level set by the limiter clip word
          clip_y[ch] <= (vol > signed'(lim_w[LW_CLIP])) ? lim_w[LW_CLIP]
            : (vol < -signed'(lim_w[LW_CLIP])) ? -lim_w[LW_CLIP] : vol;
        end
      end
    end
  endgenerate
  // limiter words: soften alpha, threshold, attack rate, release rate, clip level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lim_gain <= adp_pkg::UNITY_Q824;
      lim_state <= adp_pkg::LIM_HOLD;
    end else if (smp_en) begin
      case (lim_state)
        adp_pkg::LIM_HOLD, adp_pkg::LIM_ENGAGE, adp_pkg::LIM_RELEASE: begin
          if ((lim_env[0] > signed'(lim_w[LW_THRESH]))
              || (lim_env[1] > signed'(lim_w[LW_THRESH]))) begin
            lim_state <= adp_pkg::LIM_ENGAGE;
            lim_gain <= (lim_gain > signed'(lim_w[LW_ATTACK]))
              ? lim_gain - signed'(lim_w[LW_ATTACK]) : '0;
          end else if (lim_gain < signed'(adp_pkg::UNITY_Q824)) begin
            lim_state <= adp_pkg::LIM_RELEASE;
            lim_gain <= sadd(lim_gain, lim_w[LW_RELEASE]) > signed'(adp_pkg::UNITY_Q824)
              ? adp_pkg::UNITY_Q824 : sadd(lim_gain, lim_w[LW_RELEASE]);
          end else lim_state <= adp_pkg::LIM_HOLD;
        end
        default: lim_state <= adp_pkg::LIM_HOLD;
      endcase
    end
  end
  // level meter on raw or processed audio
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meter_l <= '0;
      meter_r <= '0;
      smp_valid <= 1'b0;
    end else begin
      smp_valid <= smp_en;
      if (smp_en) begin
        meter_l <= energy(meter_l, meter_sel ? clip_y[1] : smp_in.left, meter_alpha);
        meter_r <= energy(meter_r, meter_sel ? clip_y[0] : smp_in.right, meter_alpha);
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    // the word moves only on the valid pulse and stands for a whole sample
    if (srst) begin
      smp_out <= '0;
    end else if (smp_valid) begin
      smp_out <= {clip_y[1], clip_y[0]};
    end
  end
endmodule : adp_chain

/* verilog/adp_pkg.sv */
// constants, types and register map of the audio dynamics processing chain
// Contract
// - equaliser blends two paths by sensed level
// - blend coefficients are signed 1.31 values
// - alpha 0x58, gain 0x5C, offset 0x60
// - equaliser biquads 1.31, no gain scale
// - sense gain scale shifts blend thresholds
// - compressor feed-forward, energy then region gain
// - seven transfer parameters per compressor
// - low-pass and high-pass split at crossover
// - per-band energy, attack, decay constants
// - limiter feedback, engage release or hold
// - soften alpha and omega filter output level
// - attack rate twice attack plus release
// - fine volume gain in 2.30 format
// - boost scalar clips below rail level
// - level meter energy per channel readable
// - meter source select picks raw or processed
// - 32-bit two's complement samples and coefficients
// - checksums update on writes except book/page
// - crc and xor checksums, writable to reset
// - crc uses polynomial 0x07
// - xor covers book 0x8c except page 0
// - crc readable at 0x7e per book rules
package adp_pkg;
  localparam int DW = 32;
  localparam logic [7:0] REG_PAGE_SEL = 8'h00;
  localparam logic [7:0] REG_BOOK_SEL = 8'h7f;
  localparam logic [7:0] REG_CRC = 8'h7e;
  localparam logic [7:0] REG_XOR = 8'h7d;
  localparam logic [7:0] BOOK_ZERO = 8'h00;
  localparam logic [7:0] BOOK_COEF = 8'h8c;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_EQ = 8'h20;
  localparam logic [7:0] PAGE_MISC = 8'h21;
  localparam logic [7:0] PAGE_CMP = 8'h22;
  localparam logic [7:0] PAGE_LIM = 8'h23;
  localparam logic [7:0] PAGE_BQ = 8'h24;
  localparam logic [7:0] OFS_EQ_ALPHA = 8'h58;
  localparam logic [7:0] OFS_EQ_GAIN = 8'h5c;
  localparam logic [7:0] OFS_EQ_OFFSET = 8'h60;
  localparam logic [7:0] OFS_SENSE_GAIN = 8'h64;
  localparam logic [7:0] OFS_METER_SEL = 8'h70;
  localparam logic [7:0] OFS_FINE_VOL = 8'h74;
  localparam logic [7:0] OFS_BOOST = 8'h78;
  localparam logic [7:0] OFS_METER_ALPHA = 8'h7c;
  localparam logic [7:0] OFS_METER_L = 8'h08;
  localparam logic [7:0] OFS_METER_R = 8'h0c;
  // compressor: band b at 0x08 + b*0x30, ten words per band
  localparam logic [7:0] OFS_CMP_BASE = 8'h08;
  localparam logic [7:0] OFS_CMP_STRIDE = 8'h30;
  localparam int CMP_WORDS = 10;
  // limiter words from 0x08
  localparam logic [7:0] OFS_LIM_BASE = 8'h08;
  localparam int LIM_WORDS = 5;
  // biquads: 8 sections x 5 coefficients from 0x08
  localparam logic [7:0] OFS_BQ_BASE = 8'h08;
  localparam int BQ_COUNT = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CHK_RESET = 8'h00;
  localparam logic [DW-1:0] ONE_Q31 = 32'h7fffffff;
  localparam logic [DW-1:0] UNITY_Q230 = 32'h40000000;
  localparam logic [DW-1:0] UNITY_Q824 = 32'h01000000;
  localparam logic [DW-1:0] ALPHA_DEF = 32'h00100000;
  typedef struct packed {
    logic [DW-1:0] left;
    logic [DW-1:0] right;
  } adp_stereo_t;
  typedef struct packed {
    logic [DW-1:0] b0;
    logic [DW-1:0] b1;
    logic [DW-1:0] b2;
    logic [DW-1:0] a1;
    logic [DW-1:0] a2;
  } adp_bq_t;
  typedef enum logic [1:0] {
    LIM_HOLD = 2'b00,
    LIM_ENGAGE = 2'b01,
    LIM_RELEASE = 2'b10
  } adp_lim_t;
endpackage : adp_pkg
